// ===== logic/ilo_decode.sv
// Indexed literal offset operand decode and execute of add-W, bit-set, set-all-ones
module ilo_decode
    import ilo_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_resetn,
    input wire logic i_ext_enable,
    input wire logic i_valid,
    input wire logic [15:0] i_opcode,
    input wire logic [11:0] i_pointer_two,
    input wire logic [3:0] i_bank_select,
    input wire logic [7:0] i_accum,
    input wire logic [7:0] i_file_data,
    input wire logic [4:0] i_flags,
    output logic [11:0] o_addr,
    output logic o_indexed,
    output logic o_done,
    output logic o_file_we,
    output logic [7:0] o_file_wdata,
    output logic o_accum_we,
    output logic [7:0] o_accum_wdata,
    output logic o_flags_we,
    output logic [4:0] o_flags
);
    typedef struct packed {
        logic ext_s1;
        logic ext_s2;
        logic [11:0] addr;
        logic indexed;
        logic done;
        logic file_we;
        logic [7:0] file_wdata;
        logic accum_we;
        logic [7:0] accum_wdata;
        logic flags_we;
        logic [4:0] flags;
    } ilo_state_t;

    ilo_state_t st_r;
    ilo_state_t st_nxt;
    ilo_op_t op;
    logic [7:0] farg;
    logic acc_flag;
    logic remap;
    logic [12:0] ea_sum;
    logic [11:0] ea;
    logic [8:0] sum;
    logic [4:0] nib;

    assign farg = i_opcode[7:0];
    assign acc_flag = i_opcode[8];
    // Remap only with enable set, a=0 and f at or below 5Fh
    assign remap = st_r.ext_s2 && !acc_flag && (farg <= ILO_OFFSET_MAX);
    assign ea_sum = {1'b0, i_pointer_two} + {5'h00, farg};

    always_comb begin
        if (remap) begin
            ea = ea_sum[11:0];
        end else if (acc_flag) begin
            ea = {i_bank_select, farg};
        end else if (farg < ILO_ACCESS_SPLIT) begin
            ea = {4'h0, farg};
        end else begin
            ea = {ILO_ACCESS_HIGH_BANK, farg};
        end
    end

    always_comb begin
        if (!remap) begin
            op = ILO_OP_NONE;
        end else if (i_opcode[15:10] == ILO_OPC_ADD) begin
            op = ILO_OP_ADD;
        end else if (i_opcode[15:12] == ILO_OPC_BSET) begin
            op = ILO_OP_BSET;
        end else if (i_opcode[15:9] == ILO_OPC_FILE_ALL_ONES_OP) begin
            op = ILO_OP_FILE_ALL_ONES_OP;
        end else begin
            op = ILO_OP_NONE;
        end
    end

    assign sum = {1'b0, i_accum} + {1'b0, i_file_data};
    assign nib = {1'b0, i_accum[3:0]} + {1'b0, i_file_data[3:0]};

    always_comb begin
        st_nxt = '0;
        st_nxt.ext_s1 = i_ext_enable;
        st_nxt.ext_s2 = st_r.ext_s1;
        st_nxt.addr = ea;
        st_nxt.indexed = remap;
        st_nxt.done = i_valid;
        st_nxt.flags = i_flags;
        if (i_valid) begin
            case (op)
                ILO_OP_ADD: begin
                    st_nxt.file_we = i_opcode[9];
                    st_nxt.accum_we = !i_opcode[9];
                    st_nxt.file_wdata = sum[7:0];
                    st_nxt.accum_wdata = sum[7:0];
                    st_nxt.flags_we = 1'b1;
                    st_nxt.flags[ILO_FLAG_C] = sum[8];
                    st_nxt.flags[ILO_FLAG_DC] = nib[4];
                    st_nxt.flags[ILO_FLAG_Z] = (sum[7:0] == 8'h00);
                    st_nxt.flags[ILO_FLAG_OV] = (i_accum[7] == i_file_data[7]) && (sum[7] != i_accum[7]);
                    st_nxt.flags[ILO_FLAG_N] = sum[7];
                end
                ILO_OP_BSET: begin
                    st_nxt.file_we = 1'b1;
                    st_nxt.file_wdata = i_file_data | (8'h01 << i_opcode[11:9]);
                end
                ILO_OP_FILE_ALL_ONES_OP: begin
                    st_nxt.file_we = 1'b1;
                    st_nxt.file_wdata = ILO_ALL_ONES;
                end
                default: begin
                    st_nxt.file_we = 1'b0;
                end
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_resetn) begin
            st_r <= '{
                ext_s1: 1'b0,
                ext_s2: 1'b0,
                addr: ILO_ADDR_RST,
                indexed: 1'b0,
                done: 1'b0,
                file_we: 1'b0,
                file_wdata: ILO_ACC_RST,
                accum_we: 1'b0,
                accum_wdata: ILO_ACC_RST,
                flags_we: 1'b0,
                flags: ILO_FLAGS_RST
            };
        end else begin
            st_r <= st_nxt;
        end
    end

    assign o_addr = st_r.addr;
    assign o_indexed = st_r.indexed;
    assign o_done = st_r.done;
    assign o_file_we = st_r.file_we;
    assign o_file_wdata = st_r.file_wdata;
    assign o_accum_we = st_r.accum_we;
    assign o_accum_wdata = st_r.accum_wdata;
    assign o_flags_we = st_r.flags_we;
    assign o_flags = st_r.flags;

    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_resetn);

    remap_addr_a: assert property (remap |=> o_indexed && o_addr == $past(ea_sum[11:0]))
        else $error("indexed address wrong");
    add_dest_a: assert property (i_valid && op == ILO_OP_ADD |=> o_file_we != o_accum_we)
        else $error("add destination wrong");
    add_sum_a: assert property (i_valid && op == ILO_OP_ADD |=> o_accum_wdata == $past(i_accum) + $past(i_file_data))
        else $error("add sum wrong");
    flags_keep_a: assert property (i_valid && (op == ILO_OP_BSET || op == ILO_OP_FILE_ALL_ONES_OP) |=> !o_flags_we)
        else $error("flags touched");
    add_zero_a: assert property (o_flags_we |-> o_flags[ILO_FLAG_Z] == (o_accum_wdata == 8'h00))
        else $error("zero flag wrong");
    bset_bit_a: assert property (i_valid && op == ILO_OP_BSET |=> o_file_we && o_file_wdata[$past(i_opcode[11:9])])
        else $error("bit not set");
    file_all_ones_op_ones_a: assert property (i_valid && op == ILO_OP_FILE_ALL_ONES_OP |=> o_file_we && o_file_wdata == 8'hFF)
        else $error("not all ones");
    disabled_abs_a: assert property (!st_r.ext_s2 |=> !o_indexed && !o_file_we)
        else $error("indexed while disabled");
    bank_sel_a: assert property (!remap && acc_flag |=> o_addr[11:8] == $past(i_bank_select))
        else $error("bank select wrong");
    high_abs_a: assert property (!acc_flag && farg > 8'h5F |=> !o_indexed)
        else $error("high arg remapped");

    done_pulse_a: assert property (i_valid |=> o_done)
        else $error("done missing");
    done_idle_a: assert property (!i_valid
        |=> !o_done && !o_file_we && !o_accum_we && !o_flags_we)
        else $error("strobe without instruction");
    add_carry_a: assert property (i_valid && op == ILO_OP_ADD
        |=> o_flags[ILO_FLAG_C] == (({1'b0, $past(i_accum)} + {1'b0, $past(i_file_data)}) > 9'h0FF))
        else $error("carry flag wrong");
    add_neg_a: assert property (i_valid && op == ILO_OP_ADD |=> o_flags[ILO_FLAG_N] == o_accum_wdata[7])
        else $error("negative flag wrong");
    add_ovf_a: assert property (i_valid && op == ILO_OP_ADD
        |=> o_flags[ILO_FLAG_OV] == ($past(i_accum[7]) == $past(i_file_data[7]) && o_accum_wdata[7] != $past(i_accum[7])))
        else $error("overflow flag wrong");
    add_dc_a: assert property (i_valid && op == ILO_OP_ADD
        |=> o_flags[ILO_FLAG_DC] == (({1'b0, $past(i_accum[3:0])} + {1'b0, $past(i_file_data[3:0])}) > 5'h0F))
        else $error("digit carry wrong");
    add_file_a: assert property (i_valid && op == ILO_OP_ADD && i_opcode[9]
        |=> o_file_we && o_file_wdata == $past(i_accum) + $past(i_file_data))
        else $error("add write back wrong");
    add_acc_a: assert property (i_valid && op == ILO_OP_ADD && !i_opcode[9] |=> o_accum_we && !o_file_we)
        else $error("add to accumulator wrong");
    write_excl_a: assert property (o_file_we |-> !o_accum_we)
        else $error("two destinations");
    flags_pass_a: assert property (!(i_valid && op == ILO_OP_ADD)
        |=> o_flags == $past(i_flags) && !o_flags_we)
        else $error("flags changed");
    bset_keep_a: assert property (i_valid && op == ILO_OP_BSET
        |=> (o_file_wdata & $past(i_file_data)) == $past(i_file_data) && !o_accum_we)
        else $error("bit set lost bits");
    file_all_ones_op_acc_a: assert property (i_valid && op == ILO_OP_FILE_ALL_ONES_OP |=> !o_accum_we)
        else $error("all ones hit accumulator");
    none_quiet_a: assert property (i_valid && op == ILO_OP_NONE
        |=> !o_file_we && !o_accum_we && !o_flags_we)
        else $error("write on plain opcode");

    access_low_a: assert property (!remap && !acc_flag && farg < ILO_ACCESS_SPLIT
        |=> o_addr == {4'h0, $past(farg)})
        else $error("low access address wrong");
    access_high_a: assert property (!remap && !acc_flag && farg >= ILO_ACCESS_SPLIT
        |=> o_addr[11:8] == ILO_ACCESS_HIGH_BANK && o_addr[7:0] == $past(farg))
        else $error("high access address wrong");
    bank_low_a: assert property (acc_flag
        |=> o_addr[7:0] == $past(farg) && !o_indexed)
        else $error("banked address wrong");
    not_remap_a: assert property (!remap |=> !o_indexed)
        else $error("indexed without remap");

    cov_off_c: cover property (i_valid && !st_r.ext_s2);
    cov_add_c: cover property (i_valid && op == ILO_OP_ADD);
    cov_bset_c: cover property (i_valid && op == ILO_OP_BSET);
    cov_file_all_ones_op_c: cover property (i_valid && op == ILO_OP_FILE_ALL_ONES_OP);
    cov_bank_c: cover property (i_valid && acc_flag);
endmodule

// ===== logic/ilo_pkg.sv
// Package for the indexed literal offset decode and execute block
package ilo_pkg;
    localparam logic [7:0] ILO_OFFSET_MAX = 8'h5F;
    localparam logic [7:0] ILO_ACCESS_SPLIT = 8'h60;
    localparam logic [3:0] ILO_ACCESS_HIGH_BANK = 4'hF;
    localparam logic [5:0] ILO_OPC_ADD = 6'b0010_01;
    localparam logic [3:0] ILO_OPC_BSET = 4'b1000;
    localparam logic [6:0] ILO_OPC_FILE_ALL_ONES_OP = 7'b0110_100;
    localparam logic [7:0] ILO_ALL_ONES = 8'hFF;
    localparam logic [11:0] ILO_ADDR_RST = 12'h000;
    localparam logic [7:0] ILO_ACC_RST = 8'h00;
    localparam logic [4:0] ILO_FLAGS_RST = 5'h00;
    localparam int ILO_FLAG_C = 0;
    localparam int ILO_FLAG_DC = 1;
    localparam int ILO_FLAG_Z = 2;
    localparam int ILO_FLAG_OV = 3;
    localparam int ILO_FLAG_N = 4;
    typedef enum logic [1:0] {ILO_OP_NONE, ILO_OP_ADD, ILO_OP_BSET, ILO_OP_FILE_ALL_ONES_OP} ilo_op_t;
endpackage

// ===== tb/testbench.sv
// Self-checking bench for the indexed literal offset decode block
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin err_total++; \
    $display("Error %s expected %0h seen %0h", nm, e, g); end end
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import ilo_pkg::*;
    logic i_clk = 0, i_resetn = 0, i_ext_enable = 1, i_valid = 0;
    logic [15:0] i_opcode = 16'h0000;
    logic [11:0] i_pointer_two = 12'hA00;
    logic [3:0] i_bank_select = 4'h3;
    logic [7:0] i_accum = 8'h00, i_file_data = 8'h00;
    logic [4:0] i_flags = 5'h15;
    logic [11:0] o_addr;
    logic o_indexed, o_done, o_file_we, o_accum_we, o_flags_we;
    logic [7:0] o_file_wdata, o_accum_wdata;
    logic [4:0] o_flags;
    int err_total = 0, n_tests = 0;
    ilo_decode i_dut (.i_clk(i_clk), .i_resetn(i_resetn), .i_ext_enable(i_ext_enable), .i_valid(i_valid),
        .i_opcode(i_opcode), .i_pointer_two(i_pointer_two), .i_bank_select(i_bank_select), .i_accum(i_accum),
        .i_file_data(i_file_data), .i_flags(i_flags), .o_addr(o_addr), .o_indexed(o_indexed), .o_done(o_done),
        .o_file_we(o_file_we), .o_file_wdata(o_file_wdata), .o_accum_we(o_accum_we),
        .o_accum_wdata(o_accum_wdata), .o_flags_we(o_flags_we), .o_flags(o_flags));
    initial begin
        forever #12.5 i_clk = ~i_clk;
    end
    task automatic summarize();
        $display("Comparisons %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask
    // One instruction, outputs sampled after the answer edge
    task automatic run(input logic [15:0] op, input logic [7:0] acc, input logic [7:0] dat);
        @(posedge i_clk);
        i_opcode <= op;
        i_accum <= acc;
        i_file_data <= dat;
        i_valid <= 1'b1;
        @(posedge i_clk);
        i_valid <= 1'b0;
        #1;
    endtask
    task automatic chk(input logic [11:0] a, input logic ix, input logic fw, input logic [7:0] fd,
        input logic aw, input logic [7:0] ad, input logic gw, input logic [4:0] g);
        `CHK("o_done", 1'b1, o_done)
        `CHK("o_addr", a, o_addr)
        `CHK("o_indexed", ix, o_indexed)
        `CHK("o_file_we", fw, o_file_we)
        `CHK("o_accum_we", aw, o_accum_we)
        `CHK("o_flags_we", gw, o_flags_we)
        `CHK("o_flags", g, o_flags)
        if (fw) `CHK("o_file_wdata", fd, o_file_wdata)
        if (aw) `CHK("o_accum_wdata", ad, o_accum_wdata)
    endtask
    task automatic t_add();
        run(16'h242C, 8'h7F, 8'h01);
        chk(12'hA2C, 1, 0, 0, 1, 8'h80, 1, 5'h1A);
        run(16'h2605, 8'h80, 8'h80);
        chk(12'hA05, 1, 1, 8'h00, 0, 0, 1, 5'h0D);
    endtask
    task automatic t_bset();
        for (int b = 0; b < 8; b++) begin
            run({4'h8, 3'(b), 1'b0, 8'h0A}, 8'h00, 8'h55);
            chk(12'hA0A, 1, 1, 8'h55 | (8'h01 << b), 0, 0, 0, i_flags);
        end
    endtask
    task automatic t_file_all_ones_op();
        run(16'h682C, 8'h00, 8'h12);
        chk(12'hA2C, 1, 1, ILO_ALL_ONES, 0, 0, 0, i_flags);
    endtask
    task automatic t_bound();
        run(16'h245F, 8'h01, 8'h01);
        chk(12'hA5F, 1, 0, 0, 1, 8'h02, 1, 5'h00);
        run(16'h2460, 8'h01, 8'h01);
        chk(12'hF60, 0, 0, 0, 0, 0, 0, i_flags);
        run(16'h2505, 8'h01, 8'h01);
        chk(12'h305, 0, 0, 0, 0, 0, 0, i_flags);
    endtask
    task automatic t_off();
        i_ext_enable <= 1'b0;
        repeat (4) @(posedge i_clk);
        run(16'h682C, 8'h00, 8'h00);
        chk(12'h02C, 0, 0, 0, 0, 0, 0, i_flags);
        run(16'h2560, 8'h00, 8'h00);
        chk(12'h360, 0, 0, 0, 0, 0, 0, i_flags);
    endtask
    initial begin
        repeat (400) @(posedge i_clk);
        err_total++;
        summarize();
    end
    initial begin
        repeat (12) @(posedge i_clk);
        i_resetn <= 1'b1;
        repeat (4) @(posedge i_clk);
        t_add();
        t_bset();
        t_file_all_ones_op();
        t_bound();
        t_off();
        summarize();
    end
endmodule
